/* rtl/pllcg_pkg.sv */
// Package with register map, field layout, reset values and timing counts of the clock generator
package pllcg_pkg;
  // Clock rate of clk_i and nominal range step of the oscillator
  localparam int CLK_HZ = 25000000;
  localparam int F_NOM_HZ = 38400;
  // Word offsets (byte addresses) of the register file
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_MULT = 5'h04;
  localparam logic [4:0] OFS_RANGE = 5'h08;
  localparam logic [4:0] OFS_REFDIV = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h18;
  // Control register field positions
  localparam int CTRL_PLL_ON = 0;
  localparam int CTRL_BCS = 1;
  localparam int CTRL_AUTO = 2;
  localparam int CTRL_FTSEL = 3;
  localparam int CTRL_P_LSB = 4;
  localparam int CTRL_E_LSB = 6;
  // Status register field positions
  localparam int STAT_LOCK = 0;
  localparam int STAT_TRACK = 1;
  localparam int STAT_SRC = 2;
  localparam int STAT_SWITCH = 3;
  // Interrupt status and mask bit
  localparam int IRQ_LOCK_CHG = 0;
  // Field widths
  localparam int P_W = 2;
  localparam int E_W = 2;
  localparam int N_W = 12;
  localparam int L_W = 8;
  localparam int R_W = 4;
  // Reset values
  localparam logic [N_W-1:0] N_RST = 12'h001;
  localparam logic [L_W-1:0] L_RST = 8'h01;
  localparam logic [R_W-1:0] R_RST = 4'h1;
  // Edges of each source clock waited for during a source change
  localparam logic [1:0] SWITCH_EDGES = 2'h3;
  // Matched reference periods needed for tracking and for lock
  localparam logic [2:0] TRK_WIN = 3'h2;
  localparam logic [2:0] LOCK_WIN = 3'h4;
  // Base clock selector states, Gray coded along run, hold, done
  typedef enum logic [1:0] {
    SW_RUN = 2'b00,
    SW_HOLD = 2'b01,
    SW_DONE = 2'b11
  } pllcg_sw_t;
  // Byte-lane merge of a bus write into an old register value
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (dat & m);
  endfunction
endpackage

/* rtl/pllcg_sync.sv */
// Two-flop synchroniser for a foreign clock pin with a rise pulse
`timescale 1ns/100ps
`default_nettype none
module pllcg_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pin and synchronised view
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } pllcg_sync_t;
  pllcg_sync_t r_reg;
  pllcg_sync_t r_next;
  always_comb
  begin
    r_next = r_reg;
    r_next.s1 = pin_i;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end
  // First stage is read only by the second
  assign level_o = r_reg.s2;
  assign rise_o = r_reg.s2 & ~r_reg.s3;
endmodule // pllcg_sync
`default_nettype wire

/* rtl/pllcg_moddiv.sv */
// Modulo divider counting tick pulses, with output pulse and square clock
`timescale 1ns/100ps
`default_nettype none
module pllcg_moddiv (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Input events and modulus
  input wire logic tick_i,
  input wire logic [11:0] mod_i,
  // Divided outputs
  output logic pulse_o,
  output logic clk_o
);
  typedef struct packed {
    logic [11:0] cnt;
    logic half;
  } pllcg_div_t;
  pllcg_div_t r_reg;
  pllcg_div_t r_next;
  logic [11:0] last;
  // A zero modulus acts as one
  assign last = (mod_i == 12'h000) ? 12'h000 : mod_i - 12'h001;
  assign pulse_o = tick_i & (r_reg.cnt >= last);
  always_comb
  begin
    r_next = r_reg;
    if (pulse_o)
    begin
      r_next.cnt = 12'h000;
      r_next.half = ~r_reg.half;
    end
    else if (tick_i)
      r_next.cnt = r_reg.cnt + 12'h001;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end
  assign clk_o = r_reg.half;
endmodule // pllcg_moddiv
`default_nettype wire

/* rtl/pllcg_top.sv */
// Clock generator control: dividers, phase and lock detection, base clock selector, registers
// Function
// [RULE_01] Base clock is crystal clock or oscillator clock halved, chosen by software
// [RULE_02] Crystal clock runs at crystal rate and is buffered as loop reference
// [RULE_03] Crystal circuit runs only while the integration logic asserts its enable
// [RULE_04] Reference clock is divided by modulo factor R
// [RULE_05] Oscillator clock is divided by two to the P, then by N
// [RULE_06] Programmed centre frequency equals nominal step times L times two to E
// [RULE_07] Phase comparator emits correction pulse from divided clock phase difference
// [RULE_08] Lock detector compares divided frequencies, deciding filter mode and lock
// [RULE_09] In acquisition mode the track select bit reads clear
// [RULE_10] Tracking whenever not acquiring or track select bit set
// [RULE_11] Automatic mode lets the lock detector switch filter mode
// [RULE_12] Interrupt on entering or leaving lock when enabled
// [RULE_13] Software selects oscillator clock only after lock reads set
// [RULE_14] Lock clear while oscillator selected means severe disturbance to software
// [RULE_15] Source select bit in control register picks the base clock source
// [RULE_16] On source change base clock holds static for three edges of each clock
// [RULE_17] No oscillator select while loop off; no loop off while oscillator selected
// [RULE_18] Linear factor zero disables loop and forces crystal source
// [RULE_19] Base clock toggles on each source rising edge, giving even duty
`timescale 1ns/100ps
`default_nettype none
module pllcg_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:2] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Clock pins and integration logic enable
  input wire logic crystal_clock_i,
  input wire logic osc_output_clock_i,
  input wire logic oscillator_enable_in_i,
  // Clock outputs
  output logic crystal_run_o,
  output logic crystal_clock_o,
  output logic loop_reference_clock_o,
  output logic divided_reference_clock_o,
  output logic feedback_divided_clock_o,
  output logic base_clock_out_o,
  // Loop control outputs
  output logic loop_run_o,
  output logic phase_up_o,
  output logic phase_down_o,
  output logic filter_track_o,
  output logic [15:0] vco_range_o,
  // Interrupt
  output logic loop_cpu_interrupt_o
);
  typedef struct packed {
    logic pll_on;
    logic base_source_select;
    logic auto_bw;
    logic ftsel;
    logic [pllcg_pkg::P_W-1:0] pre_p;
    logic [pllcg_pkg::E_W-1:0] rng_e;
    logic [pllcg_pkg::N_W-1:0] mult_n;
    logic [pllcg_pkg::L_W-1:0] rng_l;
    logic [pllcg_pkg::R_W-1:0] ref_r;
    logic [2:0] pre_cnt;
    logic up;
    logic dn;
    logic [1:0] fb_cnt;
    logic [2:0] good;
    logic lock;
    logic trk;
    logic irq_stat;
    logic irq_mask;
    logic irq;
    logic cur_src;
    pllcg_pkg::pllcg_sw_t sw_st;
    logic [1:0] xc;
    logic [1:0] vc;
    logic base;
    logic xclk;
    logic rclk;
    logic ftrk;
    logic run;
    logic osc_run;
    logic [15:0] vrange;
    logic ack;
    logic [31:0] rdat;
  } pllcg_state_t;

  pllcg_state_t r_reg;
  pllcg_state_t r_next;

  logic x_lvl;
  logic x_rise;
  logic v_lvl;
  logic v_rise;
  logic en_lvl;
  logic loop_run;
  logic want_src;
  logic pre_tick;
  logic rdv_pulse;
  logic vdv_pulse;
  logic rdv_clk;
  logic vdv_clk;
  logic req;
  logic auto_trk;
  logic [2:0] pre_mask;
  logic [31:0] ctrl_v;
  logic [31:0] stat_v;

  // Foreign clocks and the enable pin are synchronised before use
  pllcg_sync u_sync_x (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(crystal_clock_i),
    .level_o(x_lvl),
    .rise_o(x_rise)
  );
  pllcg_sync u_sync_v (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(osc_output_clock_i),
    .level_o(v_lvl),
    .rise_o(v_rise)
  );
  pllcg_sync u_sync_en (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(oscillator_enable_in_i),
    .level_o(en_lvl),
    .rise_o()
  );

  // Loop runs only when switched on and L is non-zero
  assign loop_run = r_reg.pll_on & (r_reg.rng_l != '0); // [RULE_18]
  assign want_src = r_reg.base_source_select & loop_run; // [RULE_15] [RULE_18]

  // Reference divider by R, fed by crystal edges while the crystal runs and the loop runs
  pllcg_moddiv u_div_r (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(x_rise & en_lvl & loop_run), // [RULE_04]
    .mod_i({8'h00, r_reg.ref_r}),
    .pulse_o(rdv_pulse),
    .clk_o(rdv_clk)
  );

  // Prescaler by two to the P ahead of the N divider
  assign pre_mask = 3'((4'h1 << r_reg.pre_p) - 4'h1);
  assign pre_tick = v_rise & loop_run & ((r_reg.pre_cnt & pre_mask) == pre_mask); // [RULE_05]
  pllcg_moddiv u_div_n (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(pre_tick), // [RULE_05]
    .mod_i(r_reg.mult_n),
    .pulse_o(vdv_pulse),
    .clk_o(vdv_clk)
  );

  // Exactly one feedback period per reference period counts as a match
  assign auto_trk = r_reg.trk;
  assign req = cyc_i & stb_i & ~r_reg.ack;

  always_comb
  begin
    ctrl_v = '0;
    ctrl_v[pllcg_pkg::CTRL_PLL_ON] = r_reg.pll_on;
    ctrl_v[pllcg_pkg::CTRL_BCS] = r_reg.base_source_select;
    ctrl_v[pllcg_pkg::CTRL_AUTO] = r_reg.auto_bw;
    ctrl_v[pllcg_pkg::CTRL_FTSEL] = r_reg.ftrk; // [RULE_09]
    ctrl_v[pllcg_pkg::CTRL_P_LSB +: pllcg_pkg::P_W] = r_reg.pre_p;
    ctrl_v[pllcg_pkg::CTRL_E_LSB +: pllcg_pkg::E_W] = r_reg.rng_e;
    stat_v = '0;
    stat_v[pllcg_pkg::STAT_LOCK] = r_reg.lock; // [RULE_13] [RULE_14]
    stat_v[pllcg_pkg::STAT_TRACK] = r_reg.ftrk;
    stat_v[pllcg_pkg::STAT_SRC] = r_reg.cur_src;
    stat_v[pllcg_pkg::STAT_SWITCH] = (r_reg.sw_st != pllcg_pkg::SW_RUN);
  end

  always_comb
  begin : next_state
    logic [31:0] wv;
    logic n_on;
    logic n_bcs;
    logic was_lock;
    wv = '0;
    n_on = 1'b0;
    n_bcs = 1'b0;
    was_lock = r_reg.lock;
    r_next = r_reg;

    // Bus slave: one wait state, ack for one cycle, unmapped reads zero
    r_next.ack = req;
    r_next.rdat = '0;
    if (req & ~we_i)
    begin
      case ({adr_i, 2'b00})
        pllcg_pkg::OFS_CTRL: r_next.rdat = ctrl_v;
        pllcg_pkg::OFS_MULT: r_next.rdat = 32'(r_reg.mult_n);
        pllcg_pkg::OFS_RANGE: r_next.rdat = 32'(r_reg.rng_l);
        pllcg_pkg::OFS_REFDIV: r_next.rdat = 32'(r_reg.ref_r);
        pllcg_pkg::OFS_STATUS: r_next.rdat = stat_v;
        pllcg_pkg::OFS_IRQ_STAT: r_next.rdat = 32'(r_reg.irq_stat);
        pllcg_pkg::OFS_IRQ_MASK: r_next.rdat = 32'(r_reg.irq_mask);
        default: r_next.rdat = '0;
      endcase
    end
    if (req & we_i)
    begin
      case ({adr_i, 2'b00})
        pllcg_pkg::OFS_CTRL:
        begin
          wv = pllcg_pkg::wmerge(ctrl_v, dat_i, sel_i);
          n_on = wv[pllcg_pkg::CTRL_PLL_ON];
          n_bcs = wv[pllcg_pkg::CTRL_BCS];
          r_next.auto_bw = wv[pllcg_pkg::CTRL_AUTO];
          if (!r_reg.auto_bw)
            r_next.ftsel = wv[pllcg_pkg::CTRL_FTSEL]; // [RULE_10]
          r_next.pre_p = wv[pllcg_pkg::CTRL_P_LSB +: pllcg_pkg::P_W];
          r_next.rng_e = wv[pllcg_pkg::CTRL_E_LSB +: pllcg_pkg::E_W];
          // Loop on/off and source change in one write are both refused
          if ((n_on != r_reg.pll_on) && (n_bcs != r_reg.base_source_select))
          begin
            n_on = r_reg.pll_on;
            n_bcs = r_reg.base_source_select;
          end
          if (n_bcs && !r_reg.base_source_select && !loop_run)
            n_bcs = 1'b0; // [RULE_17] [RULE_18]
          if (!n_on && r_reg.base_source_select)
            n_on = 1'b1; // [RULE_17]
          r_next.pll_on = n_on;
          r_next.base_source_select = n_bcs; // [RULE_15]
        end
        pllcg_pkg::OFS_MULT:
        begin
          wv = pllcg_pkg::wmerge(32'(r_reg.mult_n), dat_i, sel_i);
          r_next.mult_n = wv[pllcg_pkg::N_W-1:0];
        end
        pllcg_pkg::OFS_RANGE:
        begin
          wv = pllcg_pkg::wmerge(32'(r_reg.rng_l), dat_i, sel_i);
          r_next.rng_l = wv[pllcg_pkg::L_W-1:0];
        end
        pllcg_pkg::OFS_REFDIV:
        begin
          wv = pllcg_pkg::wmerge(32'(r_reg.ref_r), dat_i, sel_i);
          r_next.ref_r = wv[pllcg_pkg::R_W-1:0];
        end
        pllcg_pkg::OFS_IRQ_STAT:
        begin
          if (sel_i[0] && dat_i[pllcg_pkg::IRQ_LOCK_CHG])
            r_next.irq_stat = 1'b0;
        end
        pllcg_pkg::OFS_IRQ_MASK:
        begin
          if (sel_i[0])
            r_next.irq_mask = dat_i[pllcg_pkg::IRQ_LOCK_CHG];
        end
        default: r_next.base_source_select = r_reg.base_source_select;
      endcase
    end
    // Zero L drops an oscillator selection at once
    if (r_reg.rng_l == '0)
      r_next.base_source_select = 1'b0; // [RULE_18]

    // Prescaler counts oscillator edges
    if (!loop_run)
      r_next.pre_cnt = '0;
    else if (v_rise)
      r_next.pre_cnt = r_reg.pre_cnt + 3'h1; // [RULE_05]

    // Phase comparator: first divided edge opens a pulse, the other closes it
    if (!loop_run)
    begin
      r_next.up = 1'b0;
      r_next.dn = 1'b0;
    end
    else if (rdv_pulse && !vdv_pulse)
    begin
      r_next.up = ~r_reg.dn; // [RULE_07]
      r_next.dn = 1'b0;
    end
    else if (vdv_pulse && !rdv_pulse)
    begin
      r_next.dn = ~r_reg.up; // [RULE_07]
      r_next.up = 1'b0;
    end
    else if (vdv_pulse && rdv_pulse)
    begin
      r_next.up = 1'b0;
      r_next.dn = 1'b0;
    end

    // Lock detector: feedback periods per reference period
    if (!loop_run)
    begin
      r_next.fb_cnt = '0;
      r_next.good = '0;
      r_next.trk = 1'b0;
      r_next.lock = 1'b0;
    end
    else if (rdv_pulse)
    begin
      r_next.fb_cnt = {1'b0, vdv_pulse};
      if (r_reg.fb_cnt == 2'h1)
      begin
        if (r_reg.good != pllcg_pkg::LOCK_WIN)
          r_next.good = r_reg.good + 3'h1;
        if (r_next.good >= pllcg_pkg::TRK_WIN)
          r_next.trk = 1'b1; // [RULE_08]
        if (r_next.good == pllcg_pkg::LOCK_WIN)
          r_next.lock = r_reg.auto_bw; // [RULE_08]
      end
      else
      begin
        r_next.good = '0;
        r_next.trk = 1'b0; // [RULE_08]
        r_next.lock = 1'b0;
      end
    end
    else if (vdv_pulse && r_reg.fb_cnt != 2'h3)
      r_next.fb_cnt = r_reg.fb_cnt + 2'h1;
    // Lock reads clear in manual mode
    if (!r_reg.auto_bw)
      r_next.lock = 1'b0;

    // Filter mode: automatic follows detector, manual follows software bit
    if (!loop_run)
      r_next.ftrk = 1'b0; // [RULE_09]
    else if (r_reg.auto_bw)
      r_next.ftrk = auto_trk; // [RULE_11]
    else
      r_next.ftrk = r_reg.ftsel; // [RULE_10]

    // Lock change event; a new event wins over a same-cycle clear
    if (r_reg.auto_bw && (r_next.lock != was_lock))
      r_next.irq_stat = 1'b1; // [RULE_12]
    r_next.irq = r_next.irq_stat & r_next.irq_mask; // [RULE_12]

    // Base clock selector: hold static, count edges of both clocks, then swap
    case (r_reg.sw_st)
      pllcg_pkg::SW_RUN:
      begin
        if (want_src != r_reg.cur_src)
        begin
          r_next.sw_st = pllcg_pkg::SW_HOLD; // [RULE_16]
          r_next.xc = '0;
          r_next.vc = '0;
        end
        else if (r_reg.cur_src ? v_rise : x_rise)
          r_next.base = ~r_reg.base; // [RULE_19] [RULE_01]
      end
      pllcg_pkg::SW_HOLD:
      begin
        if (x_rise && r_reg.xc != pllcg_pkg::SWITCH_EDGES)
          r_next.xc = r_reg.xc + 2'h1;
        // A stopped loop gives no edges, so its count is not awaited
        if (!loop_run)
          r_next.vc = pllcg_pkg::SWITCH_EDGES;
        else if (v_rise && r_reg.vc != pllcg_pkg::SWITCH_EDGES)
          r_next.vc = r_reg.vc + 2'h1;
        if (r_next.xc == pllcg_pkg::SWITCH_EDGES && r_next.vc == pllcg_pkg::SWITCH_EDGES)
          r_next.sw_st = pllcg_pkg::SW_DONE; // [RULE_16]
      end
      pllcg_pkg::SW_DONE:
      begin
        r_next.cur_src = want_src; // [RULE_16]
        r_next.sw_st = pllcg_pkg::SW_RUN;
      end
      default: r_next.sw_st = pllcg_pkg::SW_RUN;
    endcase

    // Crystal and reference clock copies, gated by the enable
    r_next.osc_run = en_lvl; // [RULE_03]
    r_next.xclk = x_lvl & en_lvl; // [RULE_02]
    r_next.rclk = x_lvl & en_lvl; // [RULE_02]
    r_next.run = loop_run;
    r_next.vrange = 16'(r_reg.rng_l) << r_reg.rng_e; // [RULE_06]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r_reg <= '0;
      r_reg.mult_n <= pllcg_pkg::N_RST;
      r_reg.rng_l <= pllcg_pkg::L_RST;
      r_reg.ref_r <= pllcg_pkg::R_RST;
      r_reg.sw_st <= pllcg_pkg::SW_RUN;
    end
    else
      r_reg <= r_next;
  end

  assign dat_o = r_reg.rdat;
  assign ack_o = r_reg.ack;
  assign crystal_run_o = r_reg.osc_run;
  assign crystal_clock_o = r_reg.xclk;
  assign loop_reference_clock_o = r_reg.rclk;
  assign divided_reference_clock_o = rdv_clk;
  assign feedback_divided_clock_o = vdv_clk;
  assign base_clock_out_o = r_reg.base;
  assign loop_run_o = r_reg.run;
  assign phase_up_o = r_reg.up;
  assign phase_down_o = r_reg.dn;
  assign filter_track_o = r_reg.ftrk;
  assign vco_range_o = r_reg.vrange;
  assign loop_cpu_interrupt_o = r_reg.irq;
endmodule // pllcg_top
`default_nettype wire

/* sim/pllcg_properties.sv */
// Concurrent checks on the clock generator ports
`timescale 1ns/100ps
`default_nettype none
module pllcg_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Clocks and loop
  input wire logic oscillator_enable_in_i,
  input wire logic crystal_run_o,
  input wire logic crystal_clock_o,
  input wire logic loop_reference_clock_o,
  input wire logic divided_reference_clock_o,
  input wire logic feedback_divided_clock_o,
  input wire logic base_clock_out_o,
  input wire logic loop_run_o,
  input wire logic phase_up_o,
  input wire logic phase_down_o,
  input wire logic filter_track_o,
  input wire logic loop_cpu_interrupt_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held past one cycle");
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in one cycle");
  chk_data_idle: assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  chk_ref_buffer: assert property (loop_reference_clock_o == crystal_clock_o)
    else $error("reference differs from crystal clock");
  chk_xtal_gated: assert property (!crystal_run_o |-> !crystal_clock_o)
    else $error("crystal clock while circuit stopped");
  chk_enable_stop: assert property (!oscillator_enable_in_i [*4] |-> !crystal_run_o)
    else $error("crystal runs without enable");
  chk_refdiv_idle: assert property (!crystal_run_o [*4] |-> $stable(divided_reference_clock_o))
    else $error("reference divider moves while crystal stopped");
  chk_fbdiv_idle: assert property (!loop_run_o [*4] |-> $stable(feedback_divided_clock_o))
    else $error("feedback divider moves while loop off");
  chk_base_half: assert property ($changed(base_clock_out_o) |=> $stable(base_clock_out_o))
    else $error("base clock toggled twice in a row");
  chk_phase_cause: assert property ($rose(phase_up_o) |-> $changed(divided_reference_clock_o))
    else $error("up correction without reference pulse");
  chk_phase_down: assert property ($rose(phase_down_o) |-> $changed(feedback_divided_clock_o))
    else $error("down correction without feedback pulse");
  cov_irq: cover property ($rose(loop_cpu_interrupt_o));
  cov_track: cover property ($rose(filter_track_o));
  cov_base: cover property ($changed(base_clock_out_o) && loop_run_o);
endmodule // pllcg_properties
bind pllcg_top pllcg_properties i_props (.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o, .oscillator_enable_in_i,
  .crystal_run_o, .crystal_clock_o, .loop_reference_clock_o, .divided_reference_clock_o, .feedback_divided_clock_o,
  .base_clock_out_o, .loop_run_o, .phase_up_o, .phase_down_o, .filter_track_o, .loop_cpu_interrupt_o);
`default_nettype wire

/* sim/pllcg_partner.sv */
// Behavioural crystal, oscillator and integration logic enable facing the clock generator
`timescale 1ns/100ps
`default_nettype none
module pllcg_partner (
  // Bench control
  input wire logic enable_req_i,
  input wire logic [15:0] osc_half_i,
  // Loop state from the block
  input wire logic loop_run_i,
  // Pins toward the block
  output logic oscillator_enable_o,
  output logic crystal_clock_o,
  output logic osc_output_clock_o
);
  // The integration logic owns the enable
  assign oscillator_enable_o = enable_req_i;
  // Crystal stands low while disabled, so no stale edge reaches the block
  initial
  begin
    crystal_clock_o = 1'b0;
    forever
    begin
      #300;
      crystal_clock_o <= oscillator_enable_o & ~crystal_clock_o;
    end
  end
  // Offset by half a crystal phase so both pins never move together
  initial
  begin
    osc_output_clock_o = 1'b0;
    #150;
    forever
    begin
      #(osc_half_i);
      osc_output_clock_o <= loop_run_i & ~osc_output_clock_o;
    end
  end
endmodule // pllcg_partner
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the clock generator control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [4:2] adr_i = 3'h0;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0000_0000;
  logic en = 1'b1;
  logic [15:0] osc_half = 16'h012c;
  logic [31:0] dat_o;
  logic [15:0] vco_range_o;
  logic ack_o, crystal_run_o, crystal_clock_o, loop_reference_clock_o, divided_reference_clock_o;
  logic feedback_divided_clock_o, base_clock_out_o, loop_run_o, phase_up_o, phase_down_o;
  logic filter_track_o, loop_cpu_interrupt_o;
  wire oscillator_enable_in_i, crystal_clock_i, osc_output_clock_i;
  int error_cnt = 0;
  int checks_done = 0;
  int xcnt = 0;
  int ocnt = 0;
  logic [31:0] q;
  always #20 clk_i = ~clk_i;
  pllcg_top i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .crystal_clock_i, .osc_output_clock_i, .oscillator_enable_in_i, .crystal_run_o, .crystal_clock_o,
    .loop_reference_clock_o, .divided_reference_clock_o, .feedback_divided_clock_o, .base_clock_out_o,
    .loop_run_o, .phase_up_o, .phase_down_o, .filter_track_o, .vco_range_o, .loop_cpu_interrupt_o);
  pllcg_partner i_partner (.enable_req_i(en), .osc_half_i(osc_half), .loop_run_i(loop_run_o),
    .oscillator_enable_o(oscillator_enable_in_i), .crystal_clock_o(crystal_clock_i),
    .osc_output_clock_o(osc_output_clock_i));
  always @(posedge crystal_clock_i) xcnt++;
  always @(posedge osc_output_clock_i) ocnt++;
  task automatic tally_and_finish();
    if (error_cnt == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle; read data lands in q
  task automatic wb(input logic [4:0] a, input logic w, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a[4:2];
    dat_i <= d;
    do
      @(posedge clk_i);
    // No cycle count is assumed; only the watchdog ends a wait that never sees ack
    while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    wb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    wb(a, 1'b0, 32'h0000_0000);
    check(q, exp);
  endtask
  function automatic logic pick(input int k);
    return k == 0 ? divided_reference_clock_o : k == 1 ? feedback_divided_clock_o : base_clock_out_o;
  endfunction
  // Pin rises between two toggles; the first gap is partial and discarded
  task automatic gap(input int k, input bit osc, input int exp);
    logic s;
    int c0;
    for (int i = 0; i < 2; i++)
    begin
      s = pick(k);
      c0 = osc ? ocnt : xcnt;
      repeat (500) @(posedge clk_i) if (pick(k) !== s) break;
    end
    check((osc ? ocnt : xcnt) - c0, exp);
  endtask
  task automatic wait_irq();
    repeat (3000) @(posedge clk_i) if (loop_cpu_interrupt_o === 1'b1) break;
  endtask
  task automatic t_reset();
    rd(pllcg_pkg::OFS_CTRL, 32'h0000_0000);
    rd(pllcg_pkg::OFS_MULT, 32'h0000_0001);
    rd(pllcg_pkg::OFS_RANGE, 32'h0000_0001);
    rd(pllcg_pkg::OFS_REFDIV, 32'h0000_0001);
    rd(pllcg_pkg::OFS_STATUS, 32'h0000_0000);
    rd(pllcg_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    rd(5'h1C, 32'h0000_0000);
    check(vco_range_o, 32'h0000_0001);
  endtask
  task automatic t_range();
    wr(pllcg_pkg::OFS_RANGE, 32'h0000_001a);
    for (int e = 0; e < 4; e++)
    begin
      wr(pllcg_pkg::OFS_CTRL, 32'(e << 6));
      check(vco_range_o, 32'h0000_001a << e);
    end
    wr(pllcg_pkg::OFS_CTRL, 32'h0000_0000);
  endtask
  task automatic t_refuse();
    wr(pllcg_pkg::OFS_CTRL, 32'h0000_0002);
    rd(pllcg_pkg::OFS_CTRL, 32'h0000_0000);
    wr(pllcg_pkg::OFS_CTRL, 32'h0000_0003);
    rd(pllcg_pkg::OFS_CTRL, 32'h0000_0000);
    wr(pllcg_pkg::OFS_CTRL, 32'h0000_0001);
    check(loop_run_o, 1'h1);
    wr(pllcg_pkg::OFS_RANGE, 32'h0000_0000);
    check(loop_run_o, 1'h0);
    wr(pllcg_pkg::OFS_CTRL, 32'h0000_0003);
    rd(pllcg_pkg::OFS_CTRL, 32'h0000_0001);
    wr(pllcg_pkg::OFS_RANGE, 32'h0000_0001);
    en <= 1'b0;
    repeat (8) @(posedge clk_i);
    check(crystal_run_o, 1'h0);
    en <= 1'b1;
    repeat (8) @(posedge clk_i);
    check(crystal_run_o, 1'h1);
  endtask
  task automatic t_div();
    wr(pllcg_pkg::OFS_REFDIV, 32'h0000_0002);
    wr(pllcg_pkg::OFS_MULT, 32'h0000_0003);
    wr(pllcg_pkg::OFS_CTRL, 32'h0000_0011);
    gap(0, 1'b0, 2);
    gap(1, 1'b1, 6);
    wr(pllcg_pkg::OFS_REFDIV, 32'h0000_0001);
    wr(pllcg_pkg::OFS_MULT, 32'h0000_0001);
    wr(pllcg_pkg::OFS_CTRL, 32'h0000_0001);
  endtask
  task automatic t_manual();
    check(filter_track_o, 1'h0);
    wr(pllcg_pkg::OFS_CTRL, 32'h0000_0009);
    check(filter_track_o, 1'h1);
    rd(pllcg_pkg::OFS_STATUS, 32'h0000_0002);
    wr(pllcg_pkg::OFS_CTRL, 32'h0000_0001);
  endtask
  task automatic t_lock();
    logic b;
    wr(pllcg_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    wr(pllcg_pkg::OFS_CTRL, 32'h0000_0005);
    wait_irq();
    check(loop_cpu_interrupt_o, 1'h1);
    check(filter_track_o, 1'h1);
    rd(pllcg_pkg::OFS_STATUS, 32'h0000_0003);
    rd(pllcg_pkg::OFS_CTRL, 32'h0000_000d);
    wr(pllcg_pkg::OFS_IRQ_STAT, 32'h0000_0001);
    check(loop_cpu_interrupt_o, 1'h0);
    wr(pllcg_pkg::OFS_CTRL, 32'h0000_0007);
    rd(pllcg_pkg::OFS_STATUS, 32'h0000_000b);
    b = base_clock_out_o;
    repeat (20) @(posedge clk_i);
    check(base_clock_out_o, b);
    repeat (150) @(posedge clk_i);
    rd(pllcg_pkg::OFS_STATUS, 32'h0000_0007);
    gap(2, 1'b1, 1);
    wr(pllcg_pkg::OFS_CTRL, 32'h0000_0006);
    rd(pllcg_pkg::OFS_CTRL, 32'h0000_000f);
    // Half the reference rate never gives two matches in a row
    osc_half <= 16'h0258;
    wait_irq();
    check(loop_cpu_interrupt_o, 1'h1);
    rd(pllcg_pkg::OFS_STATUS, 32'h0000_0004);
    wr(pllcg_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    check(loop_cpu_interrupt_o, 1'h0);
    rd(pllcg_pkg::OFS_IRQ_STAT, 32'h0000_0001);
    wr(pllcg_pkg::OFS_CTRL, 32'h0000_0005);
    repeat (150) @(posedge clk_i);
    gap(2, 1'b0, 1);
  endtask
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_range();
    t_refuse();
    t_div();
    t_manual();
    t_lock();
    tally_and_finish();
  end
  // The sequence needs well under a millisecond; three give ample margin
  initial
  begin
    #3_000_000;
    error_cnt++;
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
